// ===== tsei_params.svh
// constants for the time stamp event interrupt block
`ifndef TSEI_PARAMS_SVH
`define TSEI_PARAMS_SVH
`define TSEI_BANK_LO 4'h6
`define TSEI_BANK_HI 4'h7
`define TSEI_BANK_BYTES 16
`define TSEI_EMPTY_RST 1'b1
`endif

// ===== tsei_pkg.sv
// types for the time stamp event interrupt block
package tsei_pkg;
	typedef enum logic [1:0] {
		TSEI_EMPTY = 2'b00,
		TSEI_ONE = 2'b01,
		TSEI_FULL = 2'b10
	} tsei_fill_t;
endpackage

// ===== tsei_edge.sv
// rising edge detector for a factor level
`timescale 1ns/1ps
module tsei_edge
(
	input wire logic i_ref_clk,
	input wire logic i_arst_n,
	input wire logic i_level,
	output logic o_rise
);
	typedef struct packed {
		logic prev;
	} tsei_edge_st_t;
	tsei_edge_st_t st;
	tsei_edge_st_t next_st;
	always_comb
	begin
		next_st = st;
		next_st.prev = i_level;
	end
	always_ff @(posedge i_ref_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			st <= '0;
		else
			st <= next_st;
	end
	assign o_rise = i_level & ~st.prev;
endmodule // tsei_edge

// ===== tsei_ram.sv
// two bank time stamp buffer store
`timescale 1ns/1ps
`include "tsei_params.svh"
module tsei_ram
(
	input wire logic i_ref_clk,
	input wire logic i_arst_n,
	input wire logic i_we,
	input wire logic [4:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic [4:0] i_raddr,
	output logic [7:0] o_rdata
);
	// addr bit 4 selects bank, low nibble is address in bank
	logic [7:0] mem [0:2*`TSEI_BANK_BYTES-1];
	logic [7:0] rd;
	always_ff @(posedge i_ref_clk)
	begin
		if (i_we)
			mem[i_addr] <= i_wdata;
	end
	always_ff @(posedge i_ref_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			rd <= 8'h00;
		else
			rd <= mem[i_raddr];
	end
	assign o_rdata = rd;
endmodule // tsei_ram

// ===== tsei_top.sv
// time stamp event interrupt gathering with buffer status and ram mode
// Operation
// - second record written to bank 7 sets full flag, when full enable is 1
// - empty flag is 1 at reset; first record to bank 6 clears it if enabled
// - third or later capture sets overwrite flag, when overwrite enable is 1
// - buffer-status-reset trigger clears full and overwrite, sets empty
// - buffer interrupt flag is full or not empty or overwrite, if any enabled
// - each event pin trigger sets its pin flag when that pin is enabled
// - event flags clear only when software writes zero to them
// - reset output start sets reset-out flag when enabled
// - second voltage detector drop sets voltage flag when enabled
// - oscillator stop detection sets oscillator flag when enabled
// - any enabled factor sets its flag and the summary flag
// - summary flag with event irq enable drives interrupt pin low
// - summary flag ignores zero writes; clears when all factor flags clear
// - summary flag clear releases the interrupt pin
// - ram mode makes banks 6 and 7 plain readable writable storage
// - address is bank number in upper nibble, offset in lower nibble
// - fixed unused bits ignore writes and read zero
// - general purpose bits store and return what is written
// - trigger with flag-clear enable set clears full and overwrite, sets empty
`timescale 1ns/1ps
`include "tsei_params.svh"
module tsei_top
	import tsei_pkg::*;
#(
	parameter int REC_BYTES = 10
)
(
	input wire logic i_ref_clk,
	input wire logic i_arst_n,
	// enables
	input wire logic i_full_irq_enable,
	input wire logic i_empty_irq_enable,
	input wire logic i_overwrite_irq_enable,
	input wire logic i_event_pin_a_enable,
	input wire logic i_event_pin_b_enable,
	input wire logic i_reset_out_irq_enable,
	input wire logic i_voltage_drop_irq_enable,
	input wire logic i_osc_stop_irq_enable,
	input wire logic i_event_irq_enable,
	input wire logic i_overwrite_mode,
	input wire logic i_flag_clear_on_trigger_enable,
	input wire logic i_buffer_ram_mode,
	// factor sources
	input wire logic i_event_input_pin_a,
	input wire logic i_event_input_pin_b,
	input wire logic i_reset_out_active,
	input wire logic i_voltage_drop,
	input wire logic i_osc_stopped,
	// capture path: one pulse per record, bytes streamed in the cycles after it
	input wire logic i_capture,
	input wire logic i_rec_we,
	input wire logic [3:0] i_rec_idx,
	input wire logic [7:0] i_rec_data,
	input wire logic i_cmd_trigger,
	// software writes of zero to event flags, one bit per flag
	input wire logic i_evflag_clr_a,
	input wire logic i_evflag_clr_b,
	input wire logic i_evflag_clr_rst,
	input wire logic i_evflag_clr_vdrop,
	input wire logic i_evflag_clr_osc,
	// ram mode byte access, address {bank, offset}
	input wire logic i_ram_we,
	input wire logic [7:0] i_ram_addr,
	input wire logic [7:0] i_ram_wdata,
	output logic [7:0] o_ram_rdata,
	// status
	output logic o_buffer_full_flag,
	output logic o_buffer_empty_flag,
	output logic o_buffer_overwrite_flag,
	output logic o_buffer_interrupt_flag,
	output logic o_event_pin_a_flag,
	output logic o_event_pin_b_flag,
	output logic o_reset_out_event_flag,
	output logic o_voltage_drop_event_flag,
	output logic o_osc_stop_event_flag,
	output logic o_summary_event_flag,
	// open drain interrupt, low active
	output logic o_int_n_out,
	output logic o_int_n_oe
);
	// a record longer than a bank would spill into the other bank
	if (REC_BYTES < 1 || REC_BYTES > `TSEI_BANK_BYTES)
	begin : g_bad_rec_bytes
		$error("REC_BYTES out of range");
	end

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	// fill counts records since the last status reset; bank_sel and drop
	// steer the record bytes that follow a capture
	typedef struct packed {
		tsei_fill_t fill;
		logic full;
		logic empty;
		logic ovw;
		logic bank_sel;
		logic drop;
		logic ev_a;
		logic ev_b;
		logic ev_rst;
		logic ev_vd;
		logic ev_osc;
		logic summ;
	} tsei_st_t;
	tsei_st_t st;
	tsei_st_t next_st;

	logic rise_a;
	logic rise_b;
	logic rise_rst;
	logic rise_vd;
	logic rise_osc;
	logic buf_irq;
	logic mem_we;
	logic [4:0] mem_addr;
	logic [7:0] mem_wdata;
	logic [7:0] mem_rdata;
	logic ram_hit;
	logic ram_hit_q;
	logic trig_clr;
	logic cap_take;
	logic buf_en_any;
	logic [4:0] ram_idx;

	// ------------------------------------------------------------
	// controls
	// ------------------------------------------------------------
	// a status reset needs the clear enable; a bare trigger leaves the buffer alone
	assign trig_clr = i_cmd_trigger && i_flag_clear_on_trigger_enable;
	// captures are blocked in ram mode; host is expected to stop them first
	assign cap_take = i_capture && !i_buffer_ram_mode;
	assign buf_en_any = i_full_irq_enable | i_empty_irq_enable | i_overwrite_irq_enable;
	// bit 4 of the address is the low bit of the bank number, 6 or 7
	assign ram_idx = i_ram_addr[4:0];

	// ------------------------------------------------------------
	// factor edges
	// ------------------------------------------------------------
	// each factor counts on its rising edge; a level held high counts once
	tsei_edge u_edge_a
	(
		.i_ref_clk(i_ref_clk),
		.i_arst_n(i_arst_n),
		.i_level(i_event_input_pin_a),
		.o_rise(rise_a)
	);
	tsei_edge u_edge_b
	(
		.i_ref_clk(i_ref_clk),
		.i_arst_n(i_arst_n),
		.i_level(i_event_input_pin_b),
		.o_rise(rise_b)
	);
	tsei_edge u_edge_rst
	(
		.i_ref_clk(i_ref_clk),
		.i_arst_n(i_arst_n),
		.i_level(i_reset_out_active),
		.o_rise(rise_rst)
	);
	tsei_edge u_edge_vd
	(
		.i_ref_clk(i_ref_clk),
		.i_arst_n(i_arst_n),
		.i_level(i_voltage_drop),
		.o_rise(rise_vd)
	);
	tsei_edge u_edge_osc
	(
		.i_ref_clk(i_ref_clk),
		.i_arst_n(i_arst_n),
		.i_level(i_osc_stopped),
		.o_rise(rise_osc)
	);

	// bank decode reused for ram writes and reads
	function automatic logic in_buf_bank(input logic [7:0] a);
		in_buf_bank = (a[7:4] == `TSEI_BANK_LO || a[7:4] == `TSEI_BANK_HI)
			&& ({1'b0, a[3:0]} < 5'(`TSEI_BANK_BYTES));
	endfunction

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb
	begin
		next_st = st;
		// a status reset is applied first, so a capture in the same cycle
		// is taken as the first record of the emptied buffer (set wins)
		if (trig_clr)
		begin
			next_st.fill = TSEI_EMPTY;
			next_st.full = 1'b0;
			next_st.ovw = 1'b0;
			next_st.empty = `TSEI_EMPTY_RST;
		end
		if (cap_take)
		begin
			case (next_st.fill)
				TSEI_EMPTY:
				begin
					next_st.fill = TSEI_ONE;
					next_st.bank_sel = 1'b0;
					next_st.drop = 1'b0;
					if (i_empty_irq_enable)
						next_st.empty = 1'b0;
				end
				TSEI_ONE:
				begin
					next_st.fill = TSEI_FULL;
					next_st.bank_sel = 1'b1;
					next_st.drop = 1'b0;
					if (i_full_irq_enable)
						next_st.full = 1'b1;
				end
				TSEI_FULL:
				begin
					// inhibit mode keeps both banks, newest record discarded
					next_st.bank_sel = 1'b1;
					next_st.drop = !i_overwrite_mode;
					if (i_overwrite_irq_enable)
						next_st.ovw = 1'b1;
				end
				default:
					next_st.fill = TSEI_EMPTY;
			endcase
		end
		// software clear first, so a same-cycle event wins
		if (i_evflag_clr_a)
			next_st.ev_a = 1'b0;
		if (i_evflag_clr_b)
			next_st.ev_b = 1'b0;
		if (i_evflag_clr_rst)
			next_st.ev_rst = 1'b0;
		if (i_evflag_clr_vdrop)
			next_st.ev_vd = 1'b0;
		if (i_evflag_clr_osc)
			next_st.ev_osc = 1'b0;
		if (rise_a && i_event_pin_a_enable)
			next_st.ev_a = 1'b1;
		if (rise_b && i_event_pin_b_enable)
			next_st.ev_b = 1'b1;
		if (rise_rst && i_reset_out_irq_enable)
			next_st.ev_rst = 1'b1;
		if (rise_vd && i_voltage_drop_irq_enable)
			next_st.ev_vd = 1'b1;
		if (rise_osc && i_osc_stop_irq_enable)
			next_st.ev_osc = 1'b1;
		// summary follows the raw factor flags, so muting a buffer enable later
		// does not drop a pending request; writes of zero have no path here
		next_st.summ = next_st.full
			| ~next_st.empty
			| next_st.ovw
			| next_st.ev_a
			| next_st.ev_b
			| next_st.ev_rst
			| next_st.ev_vd
			| next_st.ev_osc;
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			st <= '0;
			st.empty <= `TSEI_EMPTY_RST;
		end
		else
			st <= next_st;
	end

	// ------------------------------------------------------------
	// buffer store
	// ------------------------------------------------------------
	// record bytes land in the bank chosen at capture; ram mode takes the port
	always_comb
	begin
		mem_we = 1'b0;
		mem_addr = 5'h00;
		mem_wdata = 8'h00;
		if (i_buffer_ram_mode)
		begin
			mem_we = i_ram_we && in_buf_bank(i_ram_addr);
			mem_addr = ram_idx;
			mem_wdata = i_ram_wdata;
		end
		else if (i_rec_we && !st.drop && ({1'b0, i_rec_idx} < 5'(REC_BYTES)))
		begin
			mem_we = 1'b1;
			mem_addr = {st.bank_sel, i_rec_idx};
			mem_wdata = i_rec_data;
		end
	end

	tsei_ram u_ram
	(
		.i_ref_clk(i_ref_clk),
		.i_arst_n(i_arst_n),
		.i_we(mem_we),
		.i_addr(mem_addr),
		.i_wdata(mem_wdata),
		.i_raddr(ram_idx),
		.o_rdata(mem_rdata)
	);

	assign ram_hit = in_buf_bank(i_ram_addr);
	always_ff @(posedge i_ref_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			ram_hit_q <= 1'b0;
		else
			ram_hit_q <= ram_hit;
	end
	// read data lags the address by one cycle, like the registered store
	// outside the banks the read is zero
	assign o_ram_rdata = ram_hit_q ? mem_rdata : 8'h00;

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	// the flag follows the enables as they stand; the summary keeps raw flags
	assign buf_irq = buf_en_any & (st.full | ~st.empty | st.ovw);
	assign o_buffer_full_flag = st.full;
	assign o_buffer_empty_flag = st.empty;
	assign o_buffer_overwrite_flag = st.ovw;
	assign o_buffer_interrupt_flag = buf_irq;
	assign o_event_pin_a_flag = st.ev_a;
	assign o_event_pin_b_flag = st.ev_b;
	assign o_reset_out_event_flag = st.ev_rst;
	assign o_voltage_drop_event_flag = st.ev_vd;
	assign o_osc_stop_event_flag = st.ev_osc;
	assign o_summary_event_flag = st.summ;
	// open drain: the pin only ever drives low, the enable decides when
	assign o_int_n_out = 1'b0;
	assign o_int_n_oe = st.summ & i_event_irq_enable;
endmodule // tsei_top

// ===== tsei_top_assertions.sv
// concurrent checks on the ports of the event interrupt block
`timescale 1ns/1ps
module tsei_top_checker
(
	input wire logic i_ref_clk,
	input wire logic i_arst_n,
	input wire logic i_full_irq_enable,
	input wire logic i_empty_irq_enable,
	input wire logic i_overwrite_irq_enable,
	input wire logic i_event_pin_a_enable,
	input wire logic i_event_irq_enable,
	input wire logic i_flag_clear_on_trigger_enable,
	input wire logic i_buffer_ram_mode,
	input wire logic i_event_input_pin_a,
	input wire logic i_capture,
	input wire logic i_cmd_trigger,
	input wire logic i_evflag_clr_a,
	input wire logic o_buffer_full_flag,
	input wire logic o_buffer_empty_flag,
	input wire logic o_buffer_overwrite_flag,
	input wire logic o_buffer_interrupt_flag,
	input wire logic o_event_pin_a_flag,
	input wire logic o_summary_event_flag,
	input wire logic o_int_n_out,
	input wire logic o_int_n_oe
);
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_arst_n);
	// records taken since reset or the last status reset
	logic got_rec;
	always_ff @(posedge i_ref_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			got_rec <= 1'b0;
		else
			got_rec <= (i_capture && !i_buffer_ram_mode)
				|| (got_rec && !(i_cmd_trigger && i_flag_clear_on_trigger_enable));
	end
	sequence s_first;
		i_capture && !got_rec && i_empty_irq_enable && !i_buffer_ram_mode && !i_cmd_trigger;
	endsequence
	sequence s_raise;
		$rose(o_event_pin_a_flag);
	endsequence
	property p_oe;
		o_int_n_oe == (o_summary_event_flag && i_event_irq_enable);
	endproperty
	a_oe: assert property (p_oe) else $error("interrupt pin drive mismatch");
	property p_pin;
		o_int_n_oe |-> !o_int_n_out;
	endproperty
	a_pin: assert property (p_pin) else $error("interrupt pin not driven low");
	property p_set_a;
		i_event_pin_a_enable && $rose(i_event_input_pin_a) |=> o_event_pin_a_flag;
	endproperty
	a_set_a: assert property (p_set_a) else $error("pin event flag not set");
	property p_hold_a;
		$fell(o_event_pin_a_flag) |-> $past(i_evflag_clr_a);
	endproperty
	a_hold_a: assert property (p_hold_a) else $error("pin event flag fell by itself");
	property p_buf_off;
		!(i_full_irq_enable || i_empty_irq_enable || i_overwrite_irq_enable) |->
			!o_buffer_interrupt_flag;
	endproperty
	a_buf_off: assert property (p_buf_off) else $error("buffer irq with enables off");
	property p_trig;
		i_cmd_trigger && i_flag_clear_on_trigger_enable && !i_capture |=>
			o_buffer_empty_flag && !o_buffer_full_flag && !o_buffer_overwrite_flag;
	endproperty
	a_trig: assert property (p_trig) else $error("trigger did not reset buffer");
	property p_first;
		s_first |=> !o_buffer_empty_flag;
	endproperty
	a_first: assert property (p_first) else $error("first record kept empty set");
	property p_sum;
		s_raise |-> ##[0:1] o_summary_event_flag;
	endproperty
	a_sum: assert property (p_sum) else $error("summary flag not set");
endmodule // tsei_top_checker

bind tsei_top tsei_top_checker chk_u (.*);

// ===== tsei_host.sv
// host side model of the pulled-up interrupt line
`timescale 1ns/1ps
module tsei_host
(
	input wire logic i_int_n_out,
	input wire logic i_int_n_oe,
	output logic o_int_n
);
	// a released pin floats up through the pull-up, never holding its last level
	assign o_int_n = i_int_n_oe ? i_int_n_out : 1'b1;
endmodule // tsei_host

// ===== tb_top.sv
// randomised self-checking bench for the event interrupt block
`timescale 1ns/1ps
module tb_top;
	logic i_ref_clk = 1'b0;
	logic i_arst_n = 1'b0;
	logic [2:0] ben = 3'h7;
	logic [4:0] een = 5'h00, lvl = 5'h00, clr = 5'h00, m;
	logic irq_en = 1'b1, ovm = 1'b0, fce = 1'b0, ram = 1'b0, cap = 1'b0, trg = 1'b0, we = 1'b0;
	logic [7:0] addr = 8'h00, wd = 8'h00, rdat = 8'h00;
	logic rwe = 1'b0;
	logic [3:0] ridx = 4'h0;
	logic [7:0] mem [0:31];
	logic [2:0] x;
	logic y;
	wire [7:0] rd;
	wire [4:0] ef;
	wire full, empty, ovw, bif, sum, iout, ioe, int_n;
	int error_cnt = 0, compares = 0, seed = 2, n, c;
	always #12.5 i_ref_clk = ~i_ref_clk;
	tsei_top dut_u (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_full_irq_enable(ben[2]),
		.i_empty_irq_enable(ben[1]), .i_overwrite_irq_enable(ben[0]),
		.i_event_pin_a_enable(een[0]), .i_event_pin_b_enable(een[1]),
		.i_reset_out_irq_enable(een[2]), .i_voltage_drop_irq_enable(een[3]),
		.i_osc_stop_irq_enable(een[4]), .i_event_irq_enable(irq_en), .i_overwrite_mode(ovm),
		.i_flag_clear_on_trigger_enable(fce), .i_buffer_ram_mode(ram),
		.i_event_input_pin_a(lvl[0]), .i_event_input_pin_b(lvl[1]), .i_reset_out_active(lvl[2]),
		.i_voltage_drop(lvl[3]), .i_osc_stopped(lvl[4]), .i_capture(cap), .i_rec_we(rwe),
		.i_rec_idx(ridx), .i_rec_data(rdat), .i_cmd_trigger(trg), .i_evflag_clr_a(clr[0]),
		.i_evflag_clr_b(clr[1]), .i_evflag_clr_rst(clr[2]), .i_evflag_clr_vdrop(clr[3]),
		.i_evflag_clr_osc(clr[4]), .i_ram_we(we), .i_ram_addr(addr), .i_ram_wdata(wd),
		.o_ram_rdata(rd), .o_buffer_full_flag(full), .o_buffer_empty_flag(empty),
		.o_buffer_overwrite_flag(ovw), .o_buffer_interrupt_flag(bif),
		.o_event_pin_a_flag(ef[0]), .o_event_pin_b_flag(ef[1]), .o_reset_out_event_flag(ef[2]),
		.o_voltage_drop_event_flag(ef[3]), .o_osc_stop_event_flag(ef[4]),
		.o_summary_event_flag(sum), .o_int_n_out(iout), .o_int_n_oe(ioe));
	tsei_host host_u (.i_int_n_out(iout), .i_int_n_oe(ioe), .o_int_n(int_n));
	function automatic logic [2:0] exp_buf(input int k, input logic [2:0] e);
		return {k >= 2 && e[2], !(k >= 1 && e[1]), k >= 3 && e[0]};
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		compares++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic close_out;
		$display("compares %0d errors %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic rst_chk;
		@(posedge i_ref_clk) i_arst_n <= 1'b0;
		repeat (4) @(posedge i_ref_clk);
		#1 chk({full, empty, ovw, bif, ioe}, 8'h08, "reset flags");
		chk(ef, 8'h00, "reset events");
		@(posedge i_ref_clk) i_arst_n <= 1'b1;
	endtask
	// ----------------------------------------
	// stimulus: buffer fill, events, ram mode
	// ----------------------------------------
	initial
	begin
		rst_chk();
		for (int p = 0; p < 2; p++)
		begin
			n = 0;
			for (int k = 1; k < 6; k++)
			begin
				c = (k == 3) ? 1 + ($random(seed) & 3) : 1;
				@(posedge i_ref_clk)
				begin
					ben <= p ? 3'h0 : 3'h7;
					ovm <= 1'($random(seed));
					cap <= k < 4;
					trg <= k > 3;
					fce <= k == 5;
				end
				repeat (c) @(posedge i_ref_clk);
				cap <= 1'b0;
				trg <= 1'b0;
				n = (k < 4) ? n + c : (k == 5 ? 0 : n);
				#1 x = exp_buf(n, ben);
				y = x[2] | ~x[1] | x[0];
				chk({full, empty, ovw}, x, "buffer");
				chk(bif, y, "buffer irq");
				#25 chk({sum, int_n}, {y, ~y}, "buffer summary");
			end
		end
		for (int i = 0; i < 6; i++)
		begin
			// last pass raises every factor while clearing, so set must beat clear
			m = (i < 5) ? 5'h01 << i : 5'h1f;
			@(posedge i_ref_clk)
			begin
				een <= (i < 5) ? 5'($random(seed)) : 5'h1f;
				lvl <= m;
				clr <= (i < 5) ? 5'h00 : 5'h1f;
			end
			@(posedge i_ref_clk) lvl <= 5'h00;
			clr <= 5'h00;
			#1 chk(ef, een & m, "event set");
			#50 chk({ef, sum, int_n}, {een & m, |(een & m), ~|(een & m)}, "event hold");
			@(posedge i_ref_clk) clr <= 5'h1f;
			@(posedge i_ref_clk) clr <= 5'h00;
			#26 chk({ef, sum, int_n}, 8'h01, "event clear");
		end
		@(posedge i_ref_clk) een <= 5'h00;
		ram <= 1'b1;
		for (int a = 0; a < 32; a++)
		begin
			c = $random(seed);
			mem[a] = 8'(c);
			@(posedge i_ref_clk) we <= 1'b1;
			addr <= 8'(8'h60 + a);
			wd <= 8'(c);
		end
		@(posedge i_ref_clk) we <= 1'b0;
		ram <= 1'b0;
		// three records: bank 6, bank 7, then one that only overwrite mode keeps
		for (int k = 0; k < 3; k++)
		begin
			c = $random(seed);
			n = ((c >> 8) & 255) % 10;
			@(posedge i_ref_clk) cap <= 1'b1;
			@(posedge i_ref_clk) cap <= 1'b0;
			rwe <= 1'b1;
			ridx <= 4'(n);
			rdat <= 8'(c);
			@(posedge i_ref_clk) rwe <= 1'b0;
			if (k < 2 || ovm)
				mem[(k > 0 ? 16 : 0) + n] = 8'(c);
		end
		@(posedge i_ref_clk) ram <= 1'b1;
		for (int a = 31; a >= 0; a--)
		begin
			@(posedge i_ref_clk) addr <= 8'(8'h60 + a);
			@(posedge i_ref_clk) #1 chk(rd, mem[a], "ram");
		end
		rst_chk();
		close_out();
	end
	initial
	begin
		repeat (20000) @(posedge i_ref_clk);
		error_cnt++;
		$display("mismatch at %0t: run did not finish", $time);
		close_out();
	end
endmodule // tb_top
